// ===== hdl/fault_sleep_pkg.sv
// Purpose: Shared constants for fault escalation and sleep control
// Assumes: Priority numbers where a lower value is more urgent
// Notes:   Flag positions are bit indices of the status outputs
package fault_sleep_pkg;
    localparam int PRIO_W    = 8;
    localparam int ADDR_W    = 32;
    localparam int NUM_CLS   = 3;
    localparam int CLS_MEM   = 0;
    localparam int CLS_BUS   = 1;
    localparam int CLS_USAGE = 2;

    // Class of the handler now executing
    localparam logic [2:0] ACT_NONE  = 3'h0;
    localparam logic [2:0] ACT_MEM   = 3'h1;
    localparam logic [2:0] ACT_BUS   = 3'h2;
    localparam logic [2:0] ACT_USAGE = 3'h3;
    localparam logic [2:0] ACT_HARD  = 3'h4;
    localparam logic [2:0] ACT_NMI   = 3'h5;
    localparam logic [2:0] ACT_OTHER = 3'h6;
    localparam logic [2:0] CLS_ACT [NUM_CLS] = '{ACT_MEM, ACT_BUS, ACT_USAGE};

    // Status layouts
    localparam int HARD_W       = 2;
    localparam int HARD_VEC_BIT = 0;
    localparam int HARD_ESC_BIT = 1;
    localparam int BUS_W        = 5;
    localparam int BUS_STK_BIT  = 0;
    localparam int BUS_UNSTK_BIT = 1;
    localparam int BUS_PREF_BIT = 2;
    localparam int BUS_PREC_BIT = 3;
    localparam int BUS_IMPR_BIT = 4;
    localparam int USG_W        = 6;
    localparam int USG_COP_BIT  = 0;
    localparam int USG_UNDEF_BIT = 1;
    localparam int USG_ISA_BIT  = 2;
    localparam int USG_RET_BIT  = 3;
    localparam int USG_ALIGN_BIT = 4;
    localparam int USG_DIV_BIT  = 5;
    localparam int MEM_W        = 1;
    localparam int MEM_EXEC_BIT = 0;

    // Reset values
    localparam logic [HARD_W-1:0] HARD_RST = 2'h0;
    localparam logic [BUS_W-1:0]  BUS_RST  = 5'h00;
    localparam logic [USG_W-1:0]  USG_RST  = 6'h00;
    localparam logic [MEM_W-1:0]  MEM_RST  = 1'h0;
    localparam logic [ADDR_W-1:0] ADDR_RST = 32'h0000_0000;

    typedef enum logic [1:0] {
        ST_RUN       = 2'b00,
        ST_SLEEP_INT = 2'b01,
        ST_SLEEP_EVT = 2'b10,
        ST_LOCKED    = 2'b11
    } core_state_t;
endpackage : fault_sleep_pkg

// ===== hdl/fault_class_gate.sv
// Purpose: Decide whether one configurable fault class is taken or escalated
// Assumes: Context inputs describe the handler executing in this cycle
// Notes:   Pure combinational; the caller registers the outcome
`timescale 1ns/100ps
`default_nettype none
module fault_class_gate
    import fault_sleep_pkg::*;
(
    // Fault source
    input  wire logic              hit_in,
    input  wire logic              exempt_in,
    // Class configuration
    input  wire logic [PRIO_W-1:0] prio_in,
    input  wire logic              enable_in,
    // Execution context
    input  wire logic              active_in,
    input  wire logic              same_class_in,
    input  wire logic [PRIO_W-1:0] cur_prio_in,
    // Outcome
    output logic                   escalate_out,
    output logic                   take_out
);
    logic blocked;

    always_comb
    begin
        blocked = same_class_in;
        blocked = blocked | (active_in & (prio_in >= cur_prio_in));
        blocked = blocked | ~enable_in;
        escalate_out = hit_in & ~exempt_in & blocked;
        take_out = hit_in & ~(~exempt_in & blocked);
    end
endmodule : fault_class_gate
`default_nettype wire

// ===== hdl/fault_escalation_sleep_ctrl.sv
// Purpose: Fault classing, escalation, lockup and sleep entry/wakeup
// Assumes: All inputs synchronous to CLK_IN; event inputs are one-cycle pulses
// Notes:   Status flags are sticky; set wins over write-one-to-clear
`timescale 1ns/100ps
`default_nettype none
module fault_escalation_sleep_ctrl
    import fault_sleep_pkg::*;
(
    // Clock, reset, enable
    input  wire logic              CLK_IN,
    input  wire logic              RST_B_IN,
    input  wire logic              CLK_EN_IN,
    // Bus error sources
    input  wire logic              VEC_READ_ERR_IN,
    input  wire logic              STACK_ERR_IN,
    input  wire logic              UNSTACK_ERR_IN,
    input  wire logic              PREFETCH_ERR_IN,
    input  wire logic              PRECISE_ERR_IN,
    input  wire logic              IMPRECISE_ERR_IN,
    input  wire logic              ENTERING_BUS_HANDLER_IN,
    input  wire logic [ADDR_W-1:0] DATA_ADDR_IN,
    input  wire logic [ADDR_W-1:0] FETCH_ADDR_IN,
    // Memory and usage sources
    input  wire logic              NO_EXEC_FETCH_IN,
    input  wire logic              COPROC_ACCESS_IN,
    input  wire logic              UNDEF_OPCODE_IN,
    input  wire logic              ISA_STATE_ERR_IN,
    input  wire logic              BRANCH_EXCH_IN,
    input  wire logic              BRANCH_TARGET_BIT0_IN,
    input  wire logic              BAD_RETURN_IN,
    input  wire logic              MISALIGNED_IN,
    input  wire logic              ZERO_DIVISOR_IN,
    // Class configuration
    input  wire logic [PRIO_W-1:0] MEM_PRIO_IN,
    input  wire logic [PRIO_W-1:0] BUS_PRIO_IN,
    input  wire logic [PRIO_W-1:0] USAGE_PRIO_IN,
    input  wire logic              MEM_EN_IN,
    input  wire logic              BUS_EN_IN,
    input  wire logic              USAGE_EN_IN,
    // Execution context
    input  wire logic [2:0]        ACTIVE_CLASS_IN,
    input  wire logic [PRIO_W-1:0] CUR_PRIO_IN,
    input  wire logic              HARD_ACCEPT_IN,
    // Status clears, write one to clear
    input  wire logic [HARD_W-1:0] HARD_STATUS_CLR_IN,
    input  wire logic [BUS_W-1:0]  BUS_STATUS_CLR_IN,
    input  wire logic [USG_W-1:0]  USAGE_STATUS_CLR_IN,
    input  wire logic [MEM_W-1:0]  MEM_STATUS_CLR_IN,
    // Sleep control
    input  wire logic              WAIT_FOR_INTERRUPT_INSN_IN,
    input  wire logic              WAIT_FOR_EVENT_INSN_IN,
    input  wire logic              HANDLER_EXIT_IN,
    input  wire logic              SLEEP_AFTER_HANDLER_IN,
    input  wire logic              DEEP_SLEEP_SELECT_IN,
    input  wire logic              EVENT_ON_PENDING_IN,
    input  wire logic              EVENT_IN,
    input  wire logic              DEBUG_WAKE_IN,
    // Pending exception and masks
    input  wire logic              PEND_VALID_IN,
    input  wire logic [PRIO_W-1:0] PEND_PRIO_IN,
    input  wire logic              PEND_CONFIG_IN,
    input  wire logic              PEND_IS_NMI_IN,
    input  wire logic              NEW_PEND_IN,
    input  wire logic              INTERRUPT_MASK_BIT_IN,
    input  wire logic              FAULT_MASK_BIT_IN,
    // Fault requests
    output logic                   HARD_FAULT_REQ_OUT,
    output logic                   BUS_FAULT_REQ_OUT,
    output logic                   MEM_FAULT_REQ_OUT,
    output logic                   USAGE_FAULT_REQ_OUT,
    // Status and addresses
    output logic [HARD_W-1:0]      HARD_STATUS_OUT,
    output logic [BUS_W-1:0]       BUS_STATUS_OUT,
    output logic [USG_W-1:0]       USAGE_STATUS_OUT,
    output logic [MEM_W-1:0]       MEM_STATUS_OUT,
    output logic [ADDR_W-1:0]      BUS_FAULT_ADDR_OUT,
    output logic [ADDR_W-1:0]      MEM_FAULT_ADDR_OUT,
    // Core state
    output logic                   LOCKUP_OUT,
    output logic                   SLEEPING_OUT,
    output logic                   DEEP_SLEEP_OUT,
    output logic                   HALT_OUT,
    output logic                   WAKE_OUT,
    output logic                   ENTRY_OK_OUT,
    output logic                   EVENT_REG_OUT
);
    core_state_t       state;
    core_state_t       next_state;
    logic [NUM_CLS-1:0] cls_hit;
    logic [NUM_CLS-1:0] cls_esc;
    logic [NUM_CLS-1:0] cls_take;
    logic [NUM_CLS-1:0] cls_en;
    logic [PRIO_W-1:0]  cls_prio [NUM_CLS];
    logic [BUS_W-1:0]   bus_set;
    logic [USG_W-1:0]   usg_set;
    logic [HARD_W-1:0]  hard_set;
    logic               isa_err;
    logic               hard_hit;
    logic               lock_hit;
    logic               handler_active;
    logic               sufficient;
    logic               deferred_wake;
    logic               event_wake;
    logic               go_sleep_int;
    logic               next_hard_pend;
    logic               hard_pend;

    assign handler_active = (ACTIVE_CLASS_IN != ACT_NONE);
    assign isa_err = ISA_STATE_ERR_IN | (BRANCH_EXCH_IN & ~BRANCH_TARGET_BIT0_IN);

    assign bus_set = {IMPRECISE_ERR_IN, PRECISE_ERR_IN, PREFETCH_ERR_IN, UNSTACK_ERR_IN, STACK_ERR_IN};
    assign usg_set = {ZERO_DIVISOR_IN, MISALIGNED_IN, BAD_RETURN_IN, isa_err, UNDEF_OPCODE_IN, COPROC_ACCESS_IN};

    assign cls_hit[CLS_MEM]   = NO_EXEC_FETCH_IN;
    assign cls_hit[CLS_BUS]   = |bus_set;
    assign cls_hit[CLS_USAGE] = |usg_set;
    assign cls_en      = {USAGE_EN_IN, BUS_EN_IN, MEM_EN_IN};
    assign cls_prio[CLS_MEM]   = MEM_PRIO_IN;
    assign cls_prio[CLS_BUS]   = BUS_PRIO_IN;
    assign cls_prio[CLS_USAGE] = USAGE_PRIO_IN;

    generate
        for (genvar c = 0; c < NUM_CLS; c++)
        begin : g_cls
            fault_class_gate u_gate (
                .hit_in        (cls_hit[c]),
                .exempt_in     ((c == CLS_BUS) && STACK_ERR_IN && ENTERING_BUS_HANDLER_IN),
                .prio_in       (cls_prio[c]),
                .enable_in     (cls_en[c]),
                .active_in     (handler_active),
                .same_class_in (ACTIVE_CLASS_IN == CLS_ACT[c]),
                .cur_prio_in   (CUR_PRIO_IN),
                .escalate_out  (cls_esc[c]),
                .take_out      (cls_take[c])
            );
        end
    endgenerate

    assign hard_set = {|cls_esc, VEC_READ_ERR_IN};
    assign hard_hit = |hard_set;
    assign lock_hit = hard_hit & (ACTIVE_CLASS_IN == ACT_HARD);

    assign sufficient = PEND_VALID_IN & (PEND_PRIO_IN < CUR_PRIO_IN)
                      & ~(FAULT_MASK_BIT_IN & ~PEND_IS_NMI_IN)
                      & ~(INTERRUPT_MASK_BIT_IN & PEND_CONFIG_IN);
    assign deferred_wake = PEND_VALID_IN & PEND_CONFIG_IN & (PEND_PRIO_IN < CUR_PRIO_IN)
                         & INTERRUPT_MASK_BIT_IN & ~FAULT_MASK_BIT_IN;
    assign event_wake = EVENT_IN | (EVENT_ON_PENDING_IN & NEW_PEND_IN);
    assign go_sleep_int = WAIT_FOR_INTERRUPT_INSN_IN | (HANDLER_EXIT_IN & SLEEP_AFTER_HANDLER_IN);

    // Flags are sticky so software can read them after the handler runs
    always_ff @(posedge CLK_IN)
    begin
        if (!RST_B_IN)
        begin
            HARD_STATUS_OUT  <= HARD_RST;
            BUS_STATUS_OUT   <= BUS_RST;
            USAGE_STATUS_OUT <= USG_RST;
            MEM_STATUS_OUT   <= MEM_RST;
        end
        else if (CLK_EN_IN)
        begin
            HARD_STATUS_OUT  <= hard_set | (HARD_STATUS_OUT & ~HARD_STATUS_CLR_IN);
            BUS_STATUS_OUT   <= bus_set | (BUS_STATUS_OUT & ~BUS_STATUS_CLR_IN);
            USAGE_STATUS_OUT <= usg_set | (USAGE_STATUS_OUT & ~USAGE_STATUS_CLR_IN);
            MEM_STATUS_OUT   <= {NO_EXEC_FETCH_IN} | (MEM_STATUS_OUT & ~MEM_STATUS_CLR_IN);
        end
    end

    // Imprecise errors carry no usable address, so they leave it alone
    always_ff @(posedge CLK_IN)
    begin
        if (!RST_B_IN)
        begin
            BUS_FAULT_ADDR_OUT <= ADDR_RST;
            MEM_FAULT_ADDR_OUT <= ADDR_RST;
        end
        else if (CLK_EN_IN)
        begin
            if (PREFETCH_ERR_IN)
                BUS_FAULT_ADDR_OUT <= FETCH_ADDR_IN;
            else if (PRECISE_ERR_IN | STACK_ERR_IN | UNSTACK_ERR_IN)
                BUS_FAULT_ADDR_OUT <= DATA_ADDR_IN;
            if (NO_EXEC_FETCH_IN)
                MEM_FAULT_ADDR_OUT <= FETCH_ADDR_IN;
        end
    end

    assign next_hard_pend = (hard_hit & ~lock_hit) | (hard_pend & ~HARD_ACCEPT_IN);

    always_ff @(posedge CLK_IN)
    begin
        if (!RST_B_IN)
        begin
            hard_pend           <= 1'b0;
            HARD_FAULT_REQ_OUT  <= 1'b0;
            BUS_FAULT_REQ_OUT   <= 1'b0;
            MEM_FAULT_REQ_OUT   <= 1'b0;
            USAGE_FAULT_REQ_OUT <= 1'b0;
        end
        else if (CLK_EN_IN)
        begin
            hard_pend           <= next_hard_pend;
            HARD_FAULT_REQ_OUT  <= next_hard_pend & (ACTIVE_CLASS_IN != ACT_NMI)
                                 & (ACTIVE_CLASS_IN != ACT_HARD) & (next_state != ST_LOCKED);
            BUS_FAULT_REQ_OUT   <= cls_take[CLS_BUS];
            MEM_FAULT_REQ_OUT   <= cls_take[CLS_MEM];
            USAGE_FAULT_REQ_OUT <= cls_take[CLS_USAGE];
        end
    end

    always_comb
    begin
        next_state = state;
        unique case (state)
            ST_RUN:
            begin
                if (go_sleep_int)
                    next_state = ST_SLEEP_INT;
                else if (WAIT_FOR_EVENT_INSN_IN && !EVENT_REG_OUT)
                    next_state = ST_SLEEP_EVT;
            end
            ST_SLEEP_INT:
            begin
                if (sufficient || deferred_wake || DEBUG_WAKE_IN)
                    next_state = ST_RUN;
            end
            ST_SLEEP_EVT:
            begin
                if (sufficient || deferred_wake || event_wake || DEBUG_WAKE_IN)
                    next_state = ST_RUN;
            end
            ST_LOCKED:
                next_state = ST_LOCKED;
        endcase
        if (lock_hit)
            next_state = ST_LOCKED;
    end

    always_ff @(posedge CLK_IN)
    begin
        if (!RST_B_IN)
            state <= ST_RUN;
        else if (CLK_EN_IN)
            state <= next_state;
    end

    // Event bit: a new event in the consuming cycle survives
    always_ff @(posedge CLK_IN)
    begin
        if (!RST_B_IN)
            EVENT_REG_OUT <= 1'b0;
        else if (CLK_EN_IN)
            EVENT_REG_OUT <= event_wake
                           | (EVENT_REG_OUT & ~((state == ST_RUN) & WAIT_FOR_EVENT_INSN_IN & ~go_sleep_int));
    end

    // Mode select is sampled at entry so a mid-sleep write cannot switch modes
    always_ff @(posedge CLK_IN)
    begin
        if (!RST_B_IN)
        begin
            LOCKUP_OUT     <= 1'b0;
            SLEEPING_OUT   <= 1'b0;
            DEEP_SLEEP_OUT <= 1'b0;
            HALT_OUT       <= 1'b0;
            WAKE_OUT       <= 1'b0;
            ENTRY_OK_OUT   <= 1'b0;
        end
        else if (CLK_EN_IN)
        begin
            LOCKUP_OUT   <= (next_state == ST_LOCKED);
            SLEEPING_OUT <= (next_state == ST_SLEEP_INT) | (next_state == ST_SLEEP_EVT);
            HALT_OUT     <= (next_state != ST_RUN);
            if (state == ST_RUN)
                DEEP_SLEEP_OUT <= DEEP_SLEEP_SELECT_IN & (next_state != ST_RUN) & (next_state != ST_LOCKED);
            else if (next_state != state)
                DEEP_SLEEP_OUT <= 1'b0;
            WAKE_OUT     <= (state != ST_RUN) & (state != ST_LOCKED) & (next_state == ST_RUN);
            ENTRY_OK_OUT <= sufficient;
        end
    end

    sequence s_hard_in_hard;
        CLK_EN_IN && VEC_READ_ERR_IN && (ACTIVE_CLASS_IN == ACT_HARD);
    endsequence
    sequence s_stays_locked;
        (LOCKUP_OUT && HALT_OUT && !SLEEPING_OUT) [*4];
    endsequence

    property p_vec_flag;
        @(posedge CLK_IN) disable iff (!RST_B_IN)
        CLK_EN_IN && VEC_READ_ERR_IN |=> HARD_STATUS_OUT[HARD_VEC_BIT];
    endproperty
    a_vec_flag: assert property (p_vec_flag) else $error("vector read flag not set");

    property p_esc_flag;
        @(posedge CLK_IN) disable iff (!RST_B_IN)
        CLK_EN_IN && (|cls_esc) |=> HARD_STATUS_OUT[HARD_ESC_BIT];
    endproperty
    a_esc_flag: assert property (p_esc_flag) else $error("escalation flag not set");

    property p_div_flag;
        @(posedge CLK_IN) disable iff (!RST_B_IN)
        CLK_EN_IN && ZERO_DIVISOR_IN |=> USAGE_STATUS_OUT[USG_DIV_BIT];
    endproperty
    a_div_flag: assert property (p_div_flag) else $error("divide flag not set");

    property p_fetch_addr;
        @(posedge CLK_IN) disable iff (!RST_B_IN)
        CLK_EN_IN && PREFETCH_ERR_IN |=> BUS_FAULT_ADDR_OUT == $past(FETCH_ADDR_IN);
    endproperty
    a_fetch_addr: assert property (p_fetch_addr) else $error("prefetch address not captured");

    property p_disabled_esc;
        @(posedge CLK_IN) disable iff (!RST_B_IN)
        CLK_EN_IN && UNDEF_OPCODE_IN && !USAGE_EN_IN
        |=> !USAGE_FAULT_REQ_OUT && HARD_STATUS_OUT[HARD_ESC_BIT];
    endproperty
    a_disabled_esc: assert property (p_disabled_esc) else $error("disabled fault not escalated");

    property p_stack_exempt;
        @(posedge CLK_IN) disable iff (!RST_B_IN)
        CLK_EN_IN && STACK_ERR_IN && ENTERING_BUS_HANDLER_IN |=> BUS_FAULT_REQ_OUT;
    endproperty
    a_stack_exempt: assert property (p_stack_exempt) else $error("stacking error escalated");

    property p_lockup;
        @(posedge CLK_IN) disable iff (!RST_B_IN)
        s_hard_in_hard |=> s_stays_locked;
    endproperty
    a_lockup: assert property (p_lockup) else $error("lockup not held");

    property p_wfi_sleep;
        @(posedge CLK_IN) disable iff (!RST_B_IN)
        CLK_EN_IN && (state == ST_RUN) && WAIT_FOR_INTERRUPT_INSN_IN && !lock_hit
        |=> SLEEPING_OUT && HALT_OUT;
    endproperty
    a_wfi_sleep: assert property (p_wfi_sleep) else $error("wait-for-interrupt did not sleep");

    property p_wfe_skip;
        @(posedge CLK_IN) disable iff (!RST_B_IN)
        CLK_EN_IN && (state == ST_RUN) && WAIT_FOR_EVENT_INSN_IN && EVENT_REG_OUT
        && !go_sleep_int && !event_wake && !lock_hit |=> !SLEEPING_OUT && !EVENT_REG_OUT;
    endproperty
    a_wfe_skip: assert property (p_wfe_skip) else $error("set event bit not consumed");

    property p_sev_wake;
        @(posedge CLK_IN) disable iff (!RST_B_IN)
        CLK_EN_IN && (state == ST_SLEEP_EVT) && EVENT_ON_PENDING_IN && NEW_PEND_IN && !lock_hit
        |=> WAKE_OUT && !SLEEPING_OUT;
    endproperty
    a_sev_wake: assert property (p_sev_wake) else $error("new pend did not wake");

    property p_wfi_hold;
        @(posedge CLK_IN) disable iff (!RST_B_IN)
        CLK_EN_IN && (state == ST_SLEEP_INT) && !sufficient && !deferred_wake
        && !DEBUG_WAKE_IN && !lock_hit |=> SLEEPING_OUT && !WAKE_OUT;
    endproperty
    a_wfi_hold: assert property (p_wfi_hold) else $error("woke without cause");
endmodule : fault_escalation_sleep_ctrl
`default_nettype wire

// ===== verification/core_side_model.sv
// Purpose: Pipeline side that accepts hard fault requests
// Assumes: Request is a level held until accepted
// Notes:   Slow mode waits four cycles, as a busy stacking unit would
`timescale 1ns/100ps
`default_nettype none
module core_side_model
(
    // Clock and reset
    input  wire logic clk_in,
    input  wire logic rst_b_in,
    // Handshake
    input  wire logic req_in,
    input  wire logic slow_in,
    output logic      accept_out
);
    logic [2:0] wait_cnt;
    always_ff @(posedge clk_in)
    begin
        if (!rst_b_in || accept_out || !req_in)
        begin
            accept_out <= 1'b0;
            wait_cnt   <= 3'h0;
        end
        else if (wait_cnt >= (slow_in ? 3'h4 : 3'h0))
            accept_out <= 1'b1;
        else
            wait_cnt <= wait_cnt + 3'h1;
    end
endmodule : core_side_model
`default_nettype wire

// ===== verification/fault_escalation_sleep_ctrl_tb.sv
// Purpose: Self-checking bench for fault escalation and sleep control
// Assumes: Inputs change 1 ns after the rising edge
// Notes:   Seeded random priorities; one cycle with clock enable low checks that state freezes
`timescale 1ns/100ps
`default_nettype none
module fault_escalation_sleep_ctrl_tb
    import fault_sleep_pkg::*;
;
    logic CLK_IN, RST_B_IN, CLK_EN_IN, VEC_READ_ERR_IN, ENTERING_BUS_HANDLER_IN, NO_EXEC_FETCH_IN, BRANCH_EXCH_IN;
    logic BRANCH_TARGET_BIT0_IN, MEM_EN_IN, BUS_EN_IN, USAGE_EN_IN, HARD_ACCEPT_IN, WAIT_FOR_INTERRUPT_INSN_IN;
    logic WAIT_FOR_EVENT_INSN_IN, HANDLER_EXIT_IN, SLEEP_AFTER_HANDLER_IN, DEEP_SLEEP_SELECT_IN, EVENT_ON_PENDING_IN;
    logic EVENT_IN, DEBUG_WAKE_IN, PEND_VALID_IN, PEND_CONFIG_IN, PEND_IS_NMI_IN, NEW_PEND_IN, INTERRUPT_MASK_BIT_IN;
    logic FAULT_MASK_BIT_IN, HARD_FAULT_REQ_OUT, BUS_FAULT_REQ_OUT, MEM_FAULT_REQ_OUT, USAGE_FAULT_REQ_OUT, slow, esc;
    logic LOCKUP_OUT, SLEEPING_OUT, DEEP_SLEEP_OUT, HALT_OUT, WAKE_OUT, ENTRY_OK_OUT, EVENT_REG_OUT;
    wire  STACK_ERR_IN, UNSTACK_ERR_IN, PREFETCH_ERR_IN, PRECISE_ERR_IN, IMPRECISE_ERR_IN, COPROC_ACCESS_IN;
    wire  UNDEF_OPCODE_IN, ISA_STATE_ERR_IN, BAD_RETURN_IN, MISALIGNED_IN, ZERO_DIVISOR_IN;
    logic [ADDR_W-1:0] DATA_ADDR_IN, FETCH_ADDR_IN, BUS_FAULT_ADDR_OUT, MEM_FAULT_ADDR_OUT;
    logic [PRIO_W-1:0] MEM_PRIO_IN, BUS_PRIO_IN, USAGE_PRIO_IN, CUR_PRIO_IN, PEND_PRIO_IN;
    logic [2:0]        ACTIVE_CLASS_IN;
    logic [HARD_W-1:0] HARD_STATUS_CLR_IN, HARD_STATUS_OUT;
    logic [BUS_W-1:0]  BUS_STATUS_CLR_IN, BUS_STATUS_OUT, bus_src;
    logic [USG_W-1:0]  USAGE_STATUS_CLR_IN, USAGE_STATUS_OUT, usg_src;
    logic [MEM_W-1:0]  MEM_STATUS_CLR_IN, MEM_STATUS_OUT;
    int                fail_count = 0;
    int                checked = 0;
    assign {IMPRECISE_ERR_IN, PRECISE_ERR_IN, PREFETCH_ERR_IN, UNSTACK_ERR_IN, STACK_ERR_IN} = bus_src;
    assign {ZERO_DIVISOR_IN, MISALIGNED_IN, BAD_RETURN_IN, ISA_STATE_ERR_IN, UNDEF_OPCODE_IN,
            COPROC_ACCESS_IN} = usg_src;
    fault_escalation_sleep_ctrl dut_u (.*);
    core_side_model partner_u (.clk_in(CLK_IN), .rst_b_in(RST_B_IN), .req_in(HARD_FAULT_REQ_OUT), .slow_in(slow),
                               .accept_out(HARD_ACCEPT_IN));
    always #2 CLK_IN = ~CLK_IN;
    task automatic step(input int n = 1);
        repeat (n) @(posedge CLK_IN);
        #1;
    endtask : step
    task automatic chk(input logic [ADDR_W-1:0] got, input logic [ADDR_W-1:0] exp);
        checked++;
        if (got !== exp)
        begin
            fail_count++;
            $display("BAD %0t got %0h expected %0h", $time, got, exp);
        end
    endtask : chk
    task automatic conclude;
        $display("checked %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : conclude
    // Escalation when disabled, own class, or not more urgent than the running handler
    function automatic logic escalates(logic en, logic [2:0] act, logic [PRIO_W-1:0] p, logic [PRIO_W-1:0] c);
        return !en || act == ACT_USAGE || (act != ACT_NONE && p >= c);
    endfunction : escalates
    // Clears run long enough for a slow acceptance of any hard request
    task automatic clear_all;
        {HARD_STATUS_CLR_IN, BUS_STATUS_CLR_IN, USAGE_STATUS_CLR_IN, MEM_STATUS_CLR_IN} = '1;
        step(8);
        {HARD_STATUS_CLR_IN, BUS_STATUS_CLR_IN, USAGE_STATUS_CLR_IN, MEM_STATUS_CLR_IN} = '0;
    endtask : clear_all
    task automatic sleep_wake(input int k);
        DEEP_SLEEP_SELECT_IN = 1'($urandom);
        INTERRUPT_MASK_BIT_IN = 1'($urandom);
        case (k)
            0: WAIT_FOR_INTERRUPT_INSN_IN = 1;
            1: WAIT_FOR_EVENT_INSN_IN = 1;
            default: HANDLER_EXIT_IN = 1;
        endcase
        step();
        {WAIT_FOR_INTERRUPT_INSN_IN, WAIT_FOR_EVENT_INSN_IN, HANDLER_EXIT_IN} = '0;
        chk({SLEEPING_OUT, HALT_OUT, DEEP_SLEEP_OUT}, {2'b11, DEEP_SLEEP_SELECT_IN});
        {PEND_VALID_IN, PEND_PRIO_IN} = {1'b1, CUR_PRIO_IN};
        step(3);
        chk({SLEEPING_OUT, ENTRY_OK_OUT}, 2'b10);
        case (k)
            0: PEND_PRIO_IN = CUR_PRIO_IN - 8'h01;
            1: NEW_PEND_IN = 1;
            default: DEBUG_WAKE_IN = 1;
        endcase
        step();
        {NEW_PEND_IN, DEBUG_WAKE_IN, PEND_VALID_IN} = '0;
        chk({WAKE_OUT, SLEEPING_OUT, DEEP_SLEEP_OUT}, 3'b100);
        chk(ENTRY_OK_OUT, k == 0 && !INTERRUPT_MASK_BIT_IN);
    endtask : sleep_wake
    initial
    begin
        step(20000);
        fail_count++;
        conclude();
    end
    initial
    begin
        {CLK_IN, RST_B_IN, VEC_READ_ERR_IN, ENTERING_BUS_HANDLER_IN, NO_EXEC_FETCH_IN, BRANCH_EXCH_IN, HANDLER_EXIT_IN,
         BRANCH_TARGET_BIT0_IN, WAIT_FOR_INTERRUPT_INSN_IN, WAIT_FOR_EVENT_INSN_IN, EVENT_IN, DEBUG_WAKE_IN,
         NEW_PEND_IN, PEND_VALID_IN, PEND_IS_NMI_IN, INTERRUPT_MASK_BIT_IN, FAULT_MASK_BIT_IN, slow, bus_src, usg_src,
         ACTIVE_CLASS_IN, HARD_STATUS_CLR_IN, BUS_STATUS_CLR_IN, USAGE_STATUS_CLR_IN, MEM_STATUS_CLR_IN} = '0;
        {CLK_EN_IN, MEM_EN_IN, BUS_EN_IN, USAGE_EN_IN} = '1;
        {PEND_CONFIG_IN, SLEEP_AFTER_HANDLER_IN, EVENT_ON_PENDING_IN} = '1;
        void'($urandom(32'h6D0B40A2));
        {DATA_ADDR_IN, FETCH_ADDR_IN, DEEP_SLEEP_SELECT_IN} = {$urandom, $urandom, 1'b0};
        {MEM_PRIO_IN, BUS_PRIO_IN, USAGE_PRIO_IN, PEND_PRIO_IN} = $urandom;
        CUR_PRIO_IN = 8'h80;
        step(2);
        RST_B_IN = 1;
        chk({LOCKUP_OUT, SLEEPING_OUT, HARD_STATUS_OUT, BUS_STATUS_OUT, USAGE_STATUS_OUT, EVENT_REG_OUT}, '0);
        // Clock enable low: sources must be ignored
        {CLK_EN_IN, usg_src, VEC_READ_ERR_IN} = {1'b0, 6'h3F, 1'b1};
        step();
        {CLK_EN_IN, usg_src, VEC_READ_ERR_IN} = {1'b1, 6'h00, 1'b0};
        chk({HARD_FAULT_REQ_OUT, HARD_STATUS_OUT, USAGE_FAULT_REQ_OUT, USAGE_STATUS_OUT}, '0);
        for (int i = 0; i < USG_W; i++)
        begin
            usg_src = USG_W'(1 << i);
            step();
            usg_src = '0;
            chk({USAGE_FAULT_REQ_OUT, USAGE_STATUS_OUT}, {1'b1, USG_W'(1 << i)});
            clear_all();
        end
        // Exchange to an even target leaves the compact set; odd target is legal
        for (int b = 0; b < 2; b++)
        begin
            {BRANCH_EXCH_IN, BRANCH_TARGET_BIT0_IN} = {1'b1, 1'(b)};
            step();
            BRANCH_EXCH_IN = 0;
            chk({USAGE_FAULT_REQ_OUT, USAGE_STATUS_OUT}, b ? 7'h00 : 7'h44);
            clear_all();
        end
        for (int i = 0; i < BUS_W; i++)
        begin
            {bus_src, DATA_ADDR_IN} = {BUS_W'(1 << i), $urandom};
            step();
            bus_src = '0;
            chk({BUS_FAULT_REQ_OUT, BUS_STATUS_OUT}, {1'b1, BUS_W'(1 << i)});
            if (i != BUS_IMPR_BIT)
                chk(BUS_FAULT_ADDR_OUT, i == BUS_PREF_BIT ? FETCH_ADDR_IN : DATA_ADDR_IN);
            clear_all();
        end
        {NO_EXEC_FETCH_IN, VEC_READ_ERR_IN} = 2'b11;
        step();
        {NO_EXEC_FETCH_IN, VEC_READ_ERR_IN} = 2'b00;
        chk({MEM_FAULT_REQ_OUT, MEM_STATUS_OUT}, 2'b11);
        chk(MEM_FAULT_ADDR_OUT, FETCH_ADDR_IN);
        chk({HARD_FAULT_REQ_OUT, HARD_STATUS_OUT}, 3'b101);
        clear_all();
        for (int n = 0; n < 24; n++)
        begin
            ACTIVE_CLASS_IN = 3'($urandom % 5);
            if (ACTIVE_CLASS_IN == ACT_HARD)
                ACTIVE_CLASS_IN = ACT_OTHER;
            {USAGE_PRIO_IN, CUR_PRIO_IN, USAGE_EN_IN, slow} = 18'($urandom);
            if (n % 4 == 0)
                CUR_PRIO_IN = USAGE_PRIO_IN;
            esc = escalates(USAGE_EN_IN | n[0], ACTIVE_CLASS_IN, USAGE_PRIO_IN, CUR_PRIO_IN);
            USAGE_EN_IN = USAGE_EN_IN | n[0];
            usg_src = 6'h02;
            step();
            usg_src = '0;
            chk({HARD_STATUS_OUT[HARD_ESC_BIT], HARD_FAULT_REQ_OUT, USAGE_FAULT_REQ_OUT},
                {esc, esc, !esc});
            clear_all();
        end
        {ACTIVE_CLASS_IN, ENTERING_BUS_HANDLER_IN, bus_src} = {ACT_BUS, 1'b1, 5'h01};
        step();
        bus_src = '0;
        chk({HARD_STATUS_OUT[HARD_ESC_BIT], BUS_FAULT_REQ_OUT}, 2'b01);
        {ACTIVE_CLASS_IN, ENTERING_BUS_HANDLER_IN, CUR_PRIO_IN, USAGE_EN_IN} = {ACT_NONE, 1'b0, 8'h80, 1'b1};
        clear_all();
        EVENT_IN = 1;
        step();
        {EVENT_IN, WAIT_FOR_EVENT_INSN_IN} = 2'b01;
        chk(EVENT_REG_OUT, 1'b1);
        step();
        WAIT_FOR_EVENT_INSN_IN = 0;
        step();
        chk({SLEEPING_OUT, EVENT_REG_OUT}, 2'b00);
        for (int k = 0; k < 3; k++)
            sleep_wake(k);
        // Hard request withheld under NMI, raised once NMI is gone
        {ACTIVE_CLASS_IN, VEC_READ_ERR_IN} = {ACT_NMI, 1'b1};
        step();
        {ACTIVE_CLASS_IN, VEC_READ_ERR_IN} = {ACT_NONE, 1'b0};
        chk({HARD_FAULT_REQ_OUT, HARD_STATUS_OUT}, 3'b001);
        step();
        chk(HARD_FAULT_REQ_OUT, 1'b1);
        clear_all();
        {ACTIVE_CLASS_IN, VEC_READ_ERR_IN} = {ACT_HARD, 1'b1};
        step();
        VEC_READ_ERR_IN = 0;
        step(4);
        chk({LOCKUP_OUT, HALT_OUT, HARD_FAULT_REQ_OUT}, 3'b110);
        RST_B_IN = 0;
        step(2);
        RST_B_IN = 1;
        step();
        chk({LOCKUP_OUT, HALT_OUT, HARD_STATUS_OUT, EVENT_REG_OUT}, '0);
        conclude();
    end
endmodule : fault_escalation_sleep_ctrl_tb
`default_nettype wire
